// ### hdl/dacctl_pkg.sv
// Package for the DAC control block: offsets, fields, reset values
package dacctl_pkg;

	// Printed offsets are not multiples of four: they are indices
	localparam logic [7:0] DACCTL_IDX_CODE = 8'h7d;
	localparam logic [7:0] DACCTL_IDX_CTRL = 8'h7f;
	localparam logic [9:0] DACCTL_ADDR_CODE = {DACCTL_IDX_CODE, 2'h0};
	localparam logic [9:0] DACCTL_ADDR_CTRL = {DACCTL_IDX_CTRL, 2'h0};

	// Control register fields
	localparam int DACCTL_EN_BIT = 7;
	localparam int DACCTL_OE_HI = 5;
	localparam int DACCTL_OE_LO = 4;
	localparam int DACCTL_PSS_HI = 3;
	localparam int DACCTL_PSS_LO = 2;
	localparam int DACCTL_NSS_BIT = 0;
	localparam logic [7:0] DACCTL_CTRL_MASK = 8'hbd;
	localparam logic [7:0] DACCTL_CTRL_RST = 8'h00;
	localparam logic [7:0] DACCTL_CODE_RST = 8'h00;

	// Output select codes
	localparam logic [1:0] DACCTL_OE_PIN_A = 2'h2;
	localparam logic [1:0] DACCTL_OE_PIN_B = 2'h1;

	// Positive reference select codes
	typedef enum logic [1:0] {
		DACCTL_PREF_SUPPLY = 2'b00,
		DACCTL_PREF_EXT    = 2'b01,
		DACCTL_PREF_FVR2   = 2'b10,
		DACCTL_PREF_RSVD   = 2'b11
	} dacctl_pref_t;

	// Analog control word handed to the ladder
	typedef struct packed {
		logic         enable;
		logic         pinA;
		logic         pinB;
		logic         posSupply;
		logic         posExt;
		logic         posFvr2;
		logic         negExt;
		logic [7:0]   level;
	} dacctl_analog_t;

endpackage : dacctl_pkg

// ### hdl/dacctl_top.sv
// DAC control logic: Avalon-MM registers and analog steering
//
// How it works
// - Converter runs only while control bit 7 is one.
// - Select 10 drives pin A, 01 pin B, 00 and 11 none.
// - At most one output pin enabled at any time.
// - Ladder gets the n-bit code; level is Vneg plus code/2^n of span.
// - Sleep and wake leave both registers untouched.
// - Reset disables, releases both pins and clears the code.
// - Control register: enable 7, select 5:4, pos ref 3:2, neg ref 0.
// - Pos ref 00 supply, 01 external, 10 buffer two, 11 reserved.
// - Neg ref bit selects ground at zero, external at one.
// - Code register is 8-bit read-write, reset zero.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module dacctl_top
	import dacctl_pkg::*;
#(
	parameter int CODE_W = 8
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Power state
	input  wire logic        sleepMode,
	// Avalon-MM slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic      [1:0]  avs_response,
	output logic             avs_waitrequest,
	// Analog side
	output dacctl_analog_t   analogCtrl
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]        convCtrl;
	logic [CODE_W-1:0] outputCode;
	logic              accessDone;

	wire request  = avs_read | avs_write;
	wire hitCtrl  = avs_address == DACCTL_ADDR_CTRL;
	wire hitCode  = avs_address == DACCTL_ADDR_CODE;
	wire mapped   = hitCtrl | hitCode;
	wire takeNow  = request & ~accessDone;
	wire writeNow = avs_write & ~accessDone & avs_byteenable[0];
	wire [7:0] next_convCtrl = avs_writedata[7:0] & DACCTL_CTRL_MASK;
	wire [CODE_W-1:0] next_outputCode = avs_writedata[CODE_W-1:0];
	wire [31:0] readValue = hitCtrl ? {24'h000000, convCtrl} :
		hitCode ? {{(32 - CODE_W){1'b0}}, outputCode} : 32'h00000000;

	// One wait cycle, then answer; sleep does not touch the registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			convCtrl <= DACCTL_CTRL_RST;
			outputCode <= CODE_W'(DACCTL_CODE_RST);
			accessDone <= 1'b0;
			avs_readdata <= 32'h00000000;
			avs_response <= 2'h0;
			avs_waitrequest <= 1'b1;
		end else begin
			accessDone <= takeNow;
			avs_waitrequest <= ~takeNow;
			if (writeNow & hitCtrl)
				convCtrl <= next_convCtrl;
			if (writeNow & hitCode)
				outputCode <= next_outputCode;
			if (takeNow) begin
				avs_readdata <= avs_read ? readValue : 32'h00000000;
				avs_response <= mapped ? 2'h0 : 2'h2;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog steering

	wire       enabled = convCtrl[DACCTL_EN_BIT];
	wire [1:0] outSel  = convCtrl[DACCTL_OE_HI:DACCTL_OE_LO];
	wire [1:0] posSel  = convCtrl[DACCTL_PSS_HI:DACCTL_PSS_LO];
	wire       next_pinA = enabled & (outSel == DACCTL_OE_PIN_A);
	wire       next_pinB = enabled & (outSel == DACCTL_OE_PIN_B);

	// Positive reference decode, shared by the three reference lines
	function automatic logic prefHit(input logic [1:0] sel,
		input dacctl_pref_t code);
		return sel == code;
	endfunction

	wire       prefSupply = prefHit(posSel, DACCTL_PREF_SUPPLY);
	wire       prefExt    = prefHit(posSel, DACCTL_PREF_EXT);
	wire       prefFvr2   = prefHit(posSel, DACCTL_PREF_FVR2);

	dacctl_analog_t next_analog;
	always_comb begin
		next_analog = '0;
		next_analog.enable = enabled;
		next_analog.pinA = next_pinA & ~next_pinB;
		next_analog.pinB = next_pinB & ~next_pinA;
		next_analog.posSupply = enabled & prefSupply;
		next_analog.posExt = enabled & prefExt;
		next_analog.posFvr2 = enabled & prefFvr2;
		next_analog.negExt = enabled & convCtrl[DACCTL_NSS_BIT];
		next_analog.level = 8'(outputCode);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			analogCtrl <= '0;
		else
			analogCtrl <= next_analog;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_pins_onehot: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!(analogCtrl.pinA && analogCtrl.pinB))
		else $error("both output pins enabled");

	a_off_no_pin: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!analogCtrl.enable |-> !analogCtrl.pinA && !analogCtrl.pinB)
		else $error("pin driven while disabled");

	a_enable_follows: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		analogCtrl.enable == $past(convCtrl[DACCTL_EN_BIT]))
		else $error("enable does not follow control bit");

	a_pin_a_sel: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(enabled && outSel == 2'h2) |=> analogCtrl.pinA)
		else $error("pin A not selected");

	a_pin_b_sel: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(enabled && outSel == 2'h1) |=> analogCtrl.pinB)
		else $error("pin B not selected");

	a_level_code: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		analogCtrl.level == 8'($past(outputCode)))
		else $error("level does not follow code");

	a_sleep_holds: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(sleepMode && !avs_write) |=> $stable(convCtrl) && $stable(outputCode))
		else $error("registers changed in sleep");

	a_reset_clears: assert property (
		@(posedge ref_clk)
		sys_rst |=> convCtrl == 8'h00 && outputCode == '0 && !analogCtrl.pinA)
		else $error("reset did not clear");

	a_ctrl_reserved: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		convCtrl[6] == 1'b0 && convCtrl[1] == 1'b0)
		else $error("unimplemented control bit set");

	a_ctrl_write: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(writeNow && hitCtrl) |=>
			convCtrl == ($past(avs_writedata[7:0]) & 8'hbd))
		else $error("control write lost");

	a_pos_ref: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(enabled && posSel == 2'h1) |=> analogCtrl.posExt && !analogCtrl.posFvr2)
		else $error("positive reference wrong");

	a_neg_ref: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		analogCtrl.negExt == $past(enabled && convCtrl[0]))
		else $error("negative reference wrong");

	a_code_write: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(writeNow && hitCode) |=>
			outputCode == $past(avs_writedata[CODE_W-1:0]))
		else $error("code write lost");

	a_wait_mirror: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		avs_waitrequest == !accessDone)
		else $error("waitrequest out of step with access");

	a_wait_answer: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(request && !accessDone) |=> !avs_waitrequest)
		else $error("request not answered after one wait");

	a_wait_release: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

	a_wait_idle: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!request |=> avs_waitrequest)
		else $error("waitrequest low without a request");

	a_resp_unmapped: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(request && !accessDone && !mapped) |=> avs_response == 2'h2)
		else $error("unmapped access not refused");

	a_resp_okay: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(request && !accessDone && mapped) |=> avs_response == 2'h0)
		else $error("mapped access refused");

	a_read_ctrl: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(avs_read && !accessDone && hitCtrl) |=>
			avs_readdata == {24'h000000, $past(convCtrl)})
		else $error("control read data wrong");

	a_read_code: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(avs_read && !accessDone && hitCode) |=>
			avs_readdata == {{(32 - CODE_W){1'b0}}, $past(outputCode)})
		else $error("code read data wrong");

	a_read_unmapped: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(avs_read && !accessDone && !mapped) |=> avs_readdata == 32'h00000000)
		else $error("unmapped read not zero");

	a_write_rdzero: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(avs_write && !avs_read && !accessDone) |=>
			avs_readdata == 32'h00000000)
		else $error("read data not cleared on write");

	a_ctrl_hold: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!(writeNow && hitCtrl) |=> $stable(convCtrl))
		else $error("control changed without a write");

	a_code_hold: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!(writeNow && hitCode) |=> $stable(outputCode))
		else $error("code changed without a write");

	a_lane_gate: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(avs_write && !avs_byteenable[0]) |=>
			$stable(outputCode) && $stable(convCtrl))
		else $error("write stored without lane zero");

	a_unmapped_write: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(avs_write && !mapped) |=> $stable(convCtrl) && $stable(outputCode))
		else $error("unmapped write stored");

	a_access_pulse: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		accessDone |=> !accessDone)
		else $error("access held for two cycles");

	a_pos_onehot: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$onehot0({analogCtrl.posSupply, analogCtrl.posExt, analogCtrl.posFvr2}))
		else $error("two positive references selected");

	a_pos_supply: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(enabled && posSel == 2'h0) |=> analogCtrl.posSupply)
		else $error("supply reference not selected");

	a_pos_fvr2: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(enabled && posSel == 2'h2) |=> analogCtrl.posFvr2)
		else $error("buffer reference not selected");

	a_pos_rsvd: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(posSel == 2'h3) |=> !analogCtrl.posSupply && !analogCtrl.posExt &&
			!analogCtrl.posFvr2)
		else $error("reserved reference code selects a source");

	a_off_no_ref: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!analogCtrl.enable |-> !analogCtrl.posSupply && !analogCtrl.posExt &&
			!analogCtrl.posFvr2 && !analogCtrl.negExt)
		else $error("reference selected while disabled");

	a_pin_none: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(outSel == 2'h0 || outSel == 2'h3) |=>
			!analogCtrl.pinA && !analogCtrl.pinB)
		else $error("pin driven for a disabled select code");

	a_pin_off: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		!enabled |=> !analogCtrl.pinA && !analogCtrl.pinB)
		else $error("pin follows select while disabled");

	a_neg_ground: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(enabled && !convCtrl[DACCTL_NSS_BIT]) |=> !analogCtrl.negExt)
		else $error("ground not selected");

	a_level_hold: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		$stable(outputCode) |=> $stable(analogCtrl.level))
		else $error("level moved with a steady code");

	a_reset_analog: assert property (
		@(posedge ref_clk)
		sys_rst |=> analogCtrl == '0)
		else $error("analog side not cleared by reset");

	a_reset_bus: assert property (
		@(posedge ref_clk)
		sys_rst |=> avs_waitrequest && avs_response == 2'h0 &&
			avs_readdata == 32'h00000000)
		else $error("bus outputs not cleared by reset");

	a_pin_needs_en: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(analogCtrl.pinA || analogCtrl.pinB) |-> analogCtrl.enable)
		else $error("pin driven without enable");

endmodule : dacctl_top

`default_nettype wire

// ### sim/dacctl_top_tb.sv
// Self-checking bench for the DAC control block
`timescale 1ns/1ps
`default_nettype none
module dacctl_top_tb;
	import dacctl_pkg::*;
	typedef struct {
		logic [9:0] a;
		logic [7:0] w;
		logic [3:0] b;
		logic [7:0] r;
		logic [6:0] f;
		logic [7:0] l;
	} dacctl_row_t;
	logic           ref_clk = 1'b0;
	logic           sys_rst = 1'b1;
	logic           sleepMode = 1'b0;
	logic [9:0]     avs_address = 10'h000;
	logic           avs_read = 1'b0;
	logic           avs_write = 1'b0;
	logic [31:0]    avs_writedata = 32'h0;
	logic [3:0]     avs_byteenable = 4'h0;
	logic [31:0]    avs_readdata;
	logic [1:0]     avs_response;
	logic           avs_waitrequest;
	dacctl_analog_t analogCtrl;
	logic [31:0]    rd;
	logic [1:0]     rsp;
	int             nMismatch = 0;
	int             nCompared = 0;
	int             cycles = 0;
	// Write row, expected readback, expected flags and level
	dacctl_row_t rows [8] = '{
		'{DACCTL_ADDR_CTRL, 8'hff, 4'h1, 8'hbd, 7'h41, 8'h00},
		'{DACCTL_ADDR_CODE, 8'h5a, 4'h1, 8'h5a, 7'h41, 8'h5a},
		'{DACCTL_ADDR_CTRL, 8'ha0, 4'h1, 8'ha0, 7'h68, 8'h5a},
		'{DACCTL_ADDR_CTRL, 8'h95, 4'h1, 8'h95, 7'h55, 8'h5a},
		'{DACCTL_ADDR_CTRL, 8'h28, 4'h1, 8'h28, 7'h00, 8'h5a},
		'{DACCTL_ADDR_CTRL, 8'h88, 4'h1, 8'h88, 7'h42, 8'h5a},
		'{DACCTL_ADDR_CODE, 8'h33, 4'he, 8'h5a, 7'h42, 8'h5a},
		'{DACCTL_ADDR_CODE, 8'hff, 4'h1, 8'hff, 7'h42, 8'hff}};

	dacctl_top #(.CODE_W(8)) u_dut (.ref_clk, .sys_rst, .sleepMode,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_response, .avs_waitrequest, .analogCtrl);

	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			nMismatch++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		if (nMismatch == 0 && nCompared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		nCompared++;
		if (s !== e) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// Request held until waitrequest is sampled low, then released
	task automatic xfer(input logic wr, input logic [9:0] a,
		input logic [7:0] d, input logic [3:0] b);
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'hffffff, d};
		avs_byteenable <= b;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rsp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic idle;
		@(posedge ref_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].a, rows[i].w, rows[i].b);
			xfer(1'b0, rows[i].a, 8'h00, 4'hf);
			chk("readback", rd, {24'h0, rows[i].r});
			chk("response", {30'h0, rsp}, 32'h0);
			idle();
			chk("enable", analogCtrl[14], rows[i].f[6]);
			chk("pins", analogCtrl[13:12], rows[i].f[5:4]);
			chk("refs", analogCtrl[11:8], rows[i].f[3:0]);
			chk("level", analogCtrl.level, rows[i].l);
		end
		// Unmapped address is refused
		xfer(1'b0, 10'h1f8, 8'h00, 4'hf);
		chk("unmapped data", rd, 32'h0);
		chk("unmapped resp", {30'h0, rsp}, 32'h2);
		idle();
		// Sleep and wake keep both registers
		@(posedge ref_clk);
		sleepMode <= 1'b1;
		repeat (5) @(posedge ref_clk);
		sleepMode <= 1'b0;
		xfer(1'b0, DACCTL_ADDR_CTRL, 8'h00, 4'hf);
		chk("ctrl after sleep", rd, 32'h88);
		xfer(1'b0, DACCTL_ADDR_CODE, 8'h00, 4'hf);
		chk("code after sleep", rd, 32'hff);
		idle();
		// Reset in mid-run
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk("analog reset", {17'h0, analogCtrl}, 32'h0);
		xfer(1'b0, DACCTL_ADDR_CTRL, 8'h00, 4'hf);
		chk("ctrl reset", rd, 32'h0);
		xfer(1'b0, DACCTL_ADDR_CODE, 8'h00, 4'hf);
		chk("code reset", rd, 32'h0);
		idle();
		stop_test();
	end
endmodule // dacctl_top_tb
`default_nettype wire
